// *** rtl/ctvr_pkg.sv ***
`default_nettype none
package ctvr_pkg;
    // Bus timing and activity window
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CAN_WINDOW_S = 10;
    localparam longint unsigned CAN_WINDOW_CYCLES_DEF = longint'(CAN_WINDOW_S) * CLK_HZ;
    // Address modifier codes
    localparam logic [5:0] AM_A24_NP = 6'h39;
    localparam logic [5:0] AM_A24_SV = 6'h3D;
    localparam logic [5:0] AM_A32_NP = 6'h09;
    localparam logic [5:0] AM_A32_SV = 6'h0D;
    // Decoded windows, upper address bits compared
    localparam logic [31:0] A24_BASE = 32'h0068_0000;
    localparam logic [31:0] A32_BASE = 32'h5468_0000;
    localparam int WIN_LSB = 19;
    // Byte offsets of registers and memory
    localparam logic [18:0] OFS_VARIANT_ID = 19'h00000;
    localparam logic [18:0] OFS_SERIAL_REV = 19'h00002;
    localparam logic [18:0] OFS_CONTROL = 19'h00004;
    localparam logic [18:0] OFS_CONDITION = 19'h00006;
    localparam logic [18:0] OFS_SCRATCH_LOW = 19'h00008;
    localparam logic [18:0] OFS_SCRATCH_HIGH = 19'h0000A;
    localparam logic [18:0] OFS_MEM = 19'h00010;
    localparam int MEM_BYTES = 4084;
    localparam int MEM_WORDS = MEM_BYTES / 4;
    // Long-word indices derived from byte offsets
    localparam logic [16:0] LW_ID = OFS_VARIANT_ID[18:2];
    localparam logic [16:0] LW_CTRL = OFS_CONTROL[18:2];
    localparam logic [16:0] LW_SCRATCH = OFS_SCRATCH_LOW[18:2];
    localparam logic [16:0] LW_MEM = OFS_MEM[18:2];
    localparam logic [16:0] LW_MEM_END = 17'(LW_MEM + MEM_WORDS);
    // Control fields
    localparam int CTRL_CAN_RESET = 0;
    localparam int CTRL_CAN_DISABLE = 1;
    localparam int CTRL_TTC_CLEAR = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // Condition fields
    localparam int COND_TTC_LOST = 0;
    localparam int COND_CAN_ACTIVE = 1;
    localparam int COND_CRATE_LSB = 2;
    // Board type field of serial/revision register
    localparam logic [3:0] TYPE_CUSTOM = 4'h0;
    localparam logic [3:0] TYPE_VME = 4'h1;
    // Identity values, arbitrary
    localparam logic [15:0] VARIANT_ID_VME = 16'h00A1;
    localparam logic [15:0] VARIANT_ID_CUSTOM = 16'h00A2;
    // Synchroniser vector layout
    localparam int SY_AS = 0;
    localparam int SY_DS0 = 1;
    localparam int SY_DS1 = 2;
    localparam int SY_TTC = 3;
    localparam int SY_CAN = 4;
    localparam int SY_VME = 5;
    localparam int SY_GA = 6;
    localparam int SY_SER = 15;
    localparam int SY_REV = 23;
    localparam int SY_W = 27;
    localparam logic [SY_W-1:0] SY_RESET = 27'h0000007;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_RESP = 4'b0100,
        ST_ACK = 4'b1000
    } ctvr_state_t;

    typedef struct packed {
        ctvr_state_t state;
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic [SY_W-1:0] s3;
        logic [SY_W-1:0] flt;
        logic hit;
        logic wr;
        logic lword;
        logic half;
        logic [16:0] lw;
        logic [3:0] be;
        logic [31:0] wdata;
        logic [2:0] ctrl;
        logic [31:0] scratch;
        logic ttc_lost;
        logic [31:0] can_cnt;
        logic can_active;
        logic [31:0] dout;
        logic doe;
        logic dtack_oe;
        logic dtack_n;
    } ctvr_q_t;
endpackage
`default_nettype wire

// *** rtl/ctvr_regs.sv ***
`default_nettype none
module ctvr_regs
    import ctvr_pkg::*;
#(
    parameter longint unsigned CAN_WINDOW_CYCLES = CAN_WINDOW_CYCLES_DEF
)
(
    input wire logic sys_clk_in, // System clock
    input wire logic rst_in, // Synchronous reset, high
    input wire logic [31:1] vme_addr_in, // Address lines
    input wire logic [5:0] vme_am_in, // Address modifier
    input wire logic vme_as_n_in, // Address strobe, low
    input wire logic vme_ds0_n_in, // Odd byte strobe, low
    input wire logic vme_ds1_n_in, // Even byte strobe, low
    input wire logic vme_write_n_in, // Write when low
    input wire logic vme_lword_n_in, // Long-word when low, standard backplane only
    input wire logic [31:0] vme_data_in, // Data lines sensed
    output logic [31:0] vme_data_out, // Data lines driven
    output logic vme_data_oe_out, // Data drive enable
    output logic vme_dtack_n_out, // Acknowledge level
    output logic vme_dtack_oe_out, // Acknowledge drive enable
    input wire logic standard_vme_in, // Strap: 1 standard, 0 custom
    input wire logic [8:0] geo_addr_in, // Geographical address pins
    input wire logic [7:0] board_serial_in, // Serial jumpers
    input wire logic [3:0] hardware_revision_in, // Revision jumpers
    input wire logic ttc_loss_in, // Optical signal lost
    input wire logic can_activity_in, // CAN traffic seen
    output logic can_reset_out, // CAN controller reset
    output logic can_disable_out, // CAN controller disable
    output logic ttc_led_out, // Optical-loss indicator
    output logic can_led_out, // CAN activity indicator
    input wire logic [9:0] can_mem_addr_in, // CAN side word index
    input wire logic can_mem_we_in, // CAN side write
    input wire logic [31:0] can_mem_wdata_in, // CAN side write data
    output logic [31:0] can_mem_rdata_out // CAN side read data
);
    localparam logic [31:0] CAN_WIN = 32'(CAN_WINDOW_CYCLES);
    localparam ctvr_q_t Q_RESET = '{
        state: ST_IDLE,
        s1: SY_RESET,
        s2: SY_RESET,
        s3: SY_RESET,
        flt: SY_RESET,
        hit: 1'b0,
        wr: 1'b0,
        lword: 1'b0,
        half: 1'b0,
        lw: '0,
        be: '0,
        wdata: '0,
        ctrl: CTRL_RESET,
        scratch: '0,
        ttc_lost: 1'b0,
        can_cnt: '0,
        can_active: 1'b0,
        dout: '0,
        doe: 1'b0,
        dtack_oe: 1'b0,
        dtack_n: 1'b1
    };

    ctvr_q_t q_reg;
    ctvr_q_t q_next;
    logic [31:0] mem [0:MEM_WORDS-1];
    logic [31:0] mem_rd_reg;
    logic [31:0] can_rd_reg;
    logic [SY_W-1:0] raw;
    logic custom;
    logic as_act;
    logic ds_act;
    logic [1:0] be16;
    logic [8:0] ga;
    logic [3:0] crate;
    logic [15:0] variant_number;
    logic [15:0] serial_rev;
    logic [15:0] condition;
    logic a24_am;
    logic a32_am;
    logic a24_hit;
    logic a32_hit;
    logic in_mem;
    logic [9:0] mem_idx;
    logic mem_we;
    logic [31:0] rd;
    logic [31:0] merged;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign raw = {hardware_revision_in, board_serial_in, geo_addr_in, standard_vme_in,
        can_activity_in, ttc_loss_in, vme_ds1_n_in, vme_ds0_n_in, vme_as_n_in};
    assign custom = ~q_reg.flt[SY_VME];
    assign as_act = ~q_reg.flt[SY_AS];
    assign ds_act = ~q_reg.flt[SY_DS0] | ~q_reg.flt[SY_DS1];
    assign be16 = {~q_reg.flt[SY_DS1], ~q_reg.flt[SY_DS0]};
    assign ga = q_reg.flt[SY_GA +: 9];
    // Custom backplane gives true-level GA4-6, standard gives active-low GA5-8
    assign crate = custom ? {1'b0, ga[6:4]} : ~ga[8:5];
    assign variant_number = custom ? VARIANT_ID_CUSTOM : VARIANT_ID_VME;
    assign serial_rev = {custom ? TYPE_CUSTOM : TYPE_VME,
        q_reg.flt[SY_REV +: 4],
        q_reg.flt[SY_SER +: 8]};
    assign condition = {10'h000, crate, q_reg.can_active, q_reg.ttc_lost};
    assign a24_am = (vme_am_in == AM_A24_NP) || (vme_am_in == AM_A24_SV);
    assign a32_am = (vme_am_in == AM_A32_NP) || (vme_am_in == AM_A32_SV);
    assign a24_hit = vme_addr_in[23:WIN_LSB] == A24_BASE[23:WIN_LSB];
    assign a32_hit = vme_addr_in[31:WIN_LSB] == A32_BASE[31:WIN_LSB];
    assign in_mem = (q_reg.lw >= LW_MEM) && (q_reg.lw < LW_MEM_END);
    assign mem_idx = 10'(q_reg.lw - LW_MEM);
    assign mem_we = q_reg.state[2] && q_reg.hit && q_reg.wr && in_mem;

    always_comb
    begin
        case (q_reg.lw)
            LW_ID: rd = {variant_number, serial_rev};
            LW_CTRL: rd = {13'h0000, q_reg.ctrl, condition};
            LW_SCRATCH: rd = q_reg.scratch;
            default: rd = in_mem ? mem_rd_reg : 32'h0000_0000;
        endcase
    end

    assign merged = merge_bytes(q_reg.scratch, q_reg.wdata, q_reg.be);

    always_comb
    begin
        q_next = q_reg;
        q_next.s1 = raw;
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2;
        q_next.flt = (q_reg.s2 & q_reg.s3) | (q_reg.flt & (q_reg.s2 | q_reg.s3));
        // Loss sets the flag; a clear in the same cycle loses to it
        q_next.ttc_lost = q_reg.flt[SY_TTC] | q_reg.ttc_lost;
        if (q_reg.flt[SY_CAN])
        begin
            q_next.can_cnt = CAN_WIN;
        end
        else if (q_reg.can_cnt != 32'h0000_0000)
        begin
            q_next.can_cnt = q_reg.can_cnt - 32'h0000_0001;
        end
        q_next.can_active = q_reg.flt[SY_CAN] || (q_next.can_cnt != 32'h0000_0000);
        case (q_reg.state)
            ST_IDLE:
            begin
                if (as_act && ds_act)
                begin
                    q_next.hit = custom ? a24_hit
                        : ((a24_am && a24_hit) || (a32_am && a32_hit));
                    q_next.wr = ~vme_write_n_in;
                    q_next.lword = ~custom & ~vme_lword_n_in;
                    q_next.half = vme_addr_in[1];
                    q_next.lw = vme_addr_in[18:2];
                    if (~custom && ~vme_lword_n_in)
                    begin
                        q_next.be = 4'hF;
                        q_next.wdata = vme_data_in;
                    end
                    else
                    begin
                        q_next.be = vme_addr_in[1] ? {2'b00, be16} : {be16, 2'b00};
                        q_next.wdata = {vme_data_in[15:0], vme_data_in[15:0]};
                    end
                    q_next.state = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                q_next.state = ST_RESP;
            end
            ST_RESP:
            begin
                if (q_reg.hit && q_reg.wr)
                begin
                    // Only writable fields change; identity and status ignore writes
                    if (q_reg.lw == LW_CTRL && q_reg.be[2])
                    begin
                        q_next.ctrl = q_reg.wdata[18:16];
                        if (q_reg.wdata[16 + CTRL_TTC_CLEAR])
                        begin
                            q_next.ttc_lost = q_reg.flt[SY_TTC];
                        end
                    end
                    if (q_reg.lw == LW_SCRATCH)
                    begin
                        q_next.scratch = merged;
                    end
                end
                // Sampled here so a live value cannot tear mid-cycle
                if (q_reg.lword)
                begin
                    q_next.dout = rd;
                end
                else
                begin
                    q_next.dout = {16'h0000, q_reg.half ? rd[15:0] : rd[31:16]};
                end
                q_next.doe = q_reg.hit && ~q_reg.wr;
                q_next.dtack_oe = q_reg.hit;
                q_next.dtack_n = ~q_reg.hit;
                q_next.state = ST_ACK;
            end
            ST_ACK:
            begin
                if (!ds_act)
                begin
                    q_next.doe = 1'b0;
                    q_next.dtack_oe = 1'b0;
                    q_next.dtack_n = 1'b1;
                    q_next.state = ST_IDLE;
                end
            end
            default:
            begin
                q_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            q_reg <= Q_RESET;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    // A host write wins; a CAN side write in the same cycle is dropped
    always_ff @(posedge sys_clk_in)
    begin
        mem_rd_reg <= mem[mem_idx];
        can_rd_reg <= mem[can_mem_addr_in];
        if (mem_we)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (q_reg.be[i])
                begin
                    mem[mem_idx][8*i +: 8] <= q_reg.wdata[8*i +: 8];
                end
            end
        end
        else if (can_mem_we_in)
        begin
            mem[can_mem_addr_in] <= can_mem_wdata_in;
        end
    end

    assign vme_data_out = q_reg.dout;
    assign vme_data_oe_out = q_reg.doe;
    assign vme_dtack_n_out = q_reg.dtack_n;
    assign vme_dtack_oe_out = q_reg.dtack_oe;
    assign can_reset_out = q_reg.ctrl[CTRL_CAN_RESET];
    assign can_disable_out = q_reg.ctrl[CTRL_CAN_DISABLE];
    assign ttc_led_out = q_reg.ttc_lost;
    assign can_led_out = q_reg.can_active;
    assign can_mem_rdata_out = can_rd_reg;
endmodule
`default_nettype wire

// *** dv/ctvr_regs_props.sv ***
`default_nettype none
module ctvr_regs_props
    import ctvr_pkg::*;
#(
    parameter longint unsigned CAN_WINDOW_CYCLES = CAN_WINDOW_CYCLES_DEF
)
(
    input wire logic sys_clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic [31:1] vme_addr_in, // Address
    input wire logic [5:0] vme_am_in, // Modifier
    input wire logic vme_as_n_in, // Strobe
    input wire logic standard_vme_in, // Strap
    input wire logic ttc_loss_in, // Loss
    input wire logic can_activity_in, // Traffic
    input wire logic vme_data_oe_out, // Data drive
    input wire logic vme_dtack_n_out, // Ack
    input wire logic vme_dtack_oe_out, // Ack drive
    input wire logic can_reset_out, // CAN reset
    input wire logic can_disable_out, // CAN disable
    input wire logic ttc_led_out, // Loss flag
    input wire logic can_led_out // Traffic flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic a24;
    logic a32;
    logic hit;
    assign a24 = vme_addr_in[23:19] == A24_BASE[23:19];
    assign a32 = vme_addr_in[31:19] == A32_BASE[31:19];
    assign hit = !standard_vme_in ? a24 :
        (a24 && (vme_am_in == AM_A24_NP || vme_am_in == AM_A24_SV)) ||
        (a32 && (vme_am_in == AM_A32_NP || vme_am_in == AM_A32_SV));
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_ack_pair; !vme_dtack_n_out |-> vme_dtack_oe_out; endproperty
    a_ack_pair: assert property (p_ack_pair) else $error("ack without drive");
    property p_ack_time; $fell(vme_as_n_in) && hit |-> ##[4:10] !vme_dtack_n_out; endproperty
    a_ack_time: assert property (p_ack_time) else $error("decoded cycle not acked");
    property p_refuse; $fell(vme_as_n_in) && !hit |-> !vme_dtack_oe_out [*8]; endproperty
    a_refuse: assert property (p_refuse) else $error("foreign cycle acked");
    property p_release; vme_as_n_in [*8] |-> !vme_dtack_oe_out; endproperty
    a_release: assert property (p_release) else $error("ack held after release");
    property p_data_ack; vme_data_oe_out |-> vme_dtack_oe_out && !vme_dtack_n_out; endproperty
    a_data_ack: assert property (p_data_ack) else $error("data without ack");
    property p_reset_ack; $changed(can_reset_out) |-> $fell(vme_dtack_n_out); endproperty
    a_reset_ack: assert property (p_reset_ack) else $error("reset moved off write");
    property p_dis_ack; $changed(can_disable_out) |-> $fell(vme_dtack_n_out); endproperty
    a_dis_ack: assert property (p_dis_ack) else $error("disable moved off write");
    property p_loss_set; ttc_loss_in [*6] |-> ttc_led_out; endproperty
    a_loss_set: assert property (p_loss_set) else $error("loss not flagged");
    property p_loss_clr; $fell(ttc_led_out) |-> $fell(vme_dtack_n_out); endproperty
    a_loss_clr: assert property (p_loss_clr) else $error("loss flag dropped alone");
    property p_can_set; can_activity_in [*6] |-> can_led_out; endproperty
    a_can_set: assert property (p_can_set) else $error("traffic not flagged");
    c_read: cover property ($fell(vme_dtack_n_out) && vme_data_oe_out);
    c_loss_clr: cover property ($fell(ttc_led_out));
    c_can_idle: cover property ($fell(can_led_out));
endmodule
bind ctvr_regs ctvr_regs_props #(.CAN_WINDOW_CYCLES(CAN_WINDOW_CYCLES)) ctvr_regs_props_i (.*);
`default_nettype wire

// *** dv/ctvr_host.sv ***
`default_nettype none
module ctvr_host
(
    input wire logic clk_in, // Clock
    input wire logic [31:0] rdata_in, // Slave data
    input wire logic rdata_oe_in, // Slave drives
    input wire logic dtack_n_in, // Ack
    input wire logic dtack_oe_in, // Ack drive
    output logic [31:1] addr_out, // Address
    output logic [5:0] am_out, // Modifier
    output logic as_n_out, // Address strobe
    output logic ds_n_out, // Data strobes
    output logic write_n_out, // Write low
    output logic lword_n_out, // Long word low
    output logic [31:0] data_out // Data lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] drv = 32'h0;
    assign data_out = rdata_oe_in ? rdata_in : drv;
    initial
    begin
        addr_out = 31'h0;
        am_out = 6'h0;
        as_n_out = 1'h1;
        ds_n_out = 1'h1;
        write_n_out = 1'h1;
        lword_n_out = 1'h1;
    end
    task automatic xfer(input logic [31:0] a, input logic [5:0] m, input logic w,
        input logic l, input logic [31:0] wd, output logic [31:0] rd, output logic ack);
        int n;
        @(posedge clk_in);
        #1;
        addr_out = a[31:1];
        am_out = m;
        write_n_out = !w;
        lword_n_out = !l;
        drv = w ? wd : ~drv;
        as_n_out = 1'h0;
        ds_n_out = 1'h0;
        ack = 1'h0;
        rd = 32'h0;
        n = 0;
        while (!ack && n < 20)
        begin
            @(posedge clk_in);
            n++;
            ack = dtack_oe_in && !dtack_n_in;
            rd = data_out;
        end
        #1;
        as_n_out = 1'h1;
        ds_n_out = 1'h1;
        write_n_out = 1'h1;
        drv = ~drv;
        n = 0;
        // Next cycle only once the slave let go
        while ((dtack_oe_in || n < 6) && n < 20)
        begin
            @(posedge clk_in);
            n++;
        end
        // Hand back off the edge so callers never race the design's registers
        #1;
    endtask
endmodule
`default_nettype wire

// *** dv/crate_timing_vme_registers_test.sv ***
`default_nettype none
module crate_timing_vme_registers_test
    import ctvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A24 = A24_BASE;
    localparam logic [31:0] A32 = A32_BASE;
    localparam logic [31:0] ST = 32'h28;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic std_vme = 1'h1;
    logic [8:0] geo = 9'h0A5;
    logic loss = 1'h0;
    logic act = 1'h0;
    logic [9:0] ma = 10'h0;
    logic mwe = 1'h0;
    logic [31:0] mwd = 32'h0;
    logic [31:1] addr;
    logic [5:0] am;
    logic as_n, ds_n, wr_n, lw_n, doe, dtn, dtoe, crst, cdis, tled, cled;
    logic [31:0] bus, dout, mrd;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    ctvr_regs #(.CAN_WINDOW_CYCLES(20)) ctvr_regs_i (.sys_clk_in(clk), .rst_in(rst),
        .vme_addr_in(addr), .vme_am_in(am), .vme_as_n_in(as_n), .vme_ds0_n_in(ds_n),
        .vme_ds1_n_in(ds_n), .vme_write_n_in(wr_n), .vme_lword_n_in(lw_n),
        .vme_data_in(bus), .vme_data_out(dout), .vme_data_oe_out(doe),
        .vme_dtack_n_out(dtn), .vme_dtack_oe_out(dtoe), .standard_vme_in(std_vme),
        .geo_addr_in(geo), .board_serial_in(8'h05), .hardware_revision_in(4'h2),
        .ttc_loss_in(loss), .can_activity_in(act), .can_reset_out(crst),
        .can_disable_out(cdis), .ttc_led_out(tled), .can_led_out(cled),
        .can_mem_addr_in(ma), .can_mem_we_in(mwe), .can_mem_wdata_in(mwd),
        .can_mem_rdata_out(mrd));
    ctvr_host ctvr_host_i (.clk_in(clk), .rdata_in(dout), .rdata_oe_in(doe),
        .dtack_n_in(dtn), .dtack_oe_in(dtoe), .addr_out(addr), .am_out(am),
        .as_n_out(as_n), .ds_n_out(ds_n), .write_n_out(wr_n), .lword_n_out(lw_n),
        .data_out(bus));
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One bus cycle, judged on ack and read data
    task automatic acc(input logic [31:0] a, input logic [5:0] m, input logic w, input logic l,
        input logic [31:0] d, input logic [31:0] e, input logic ka);
        logic [31:0] r;
        logic k;
        ctvr_host_i.xfer(a, m, w, l, d, r, k);
        chk({31'h0, k}, {31'h0, ka});
        if (!w && ka)
            chk(l ? r : {16'h0, r[15:0]}, e);
    endtask
    task automatic wr(input logic [18:0] o, input logic [31:0] d);
        acc(A24 | {13'h0, o}, AM_A24_NP, 1'h1, 1'h0, d, 32'h0, 1'h1);
    endtask
    task automatic rd(input logic [18:0] o, input logic [31:0] e);
        acc(A24 | {13'h0, o}, AM_A24_SV, 1'h0, 1'h0, 32'h0, e, 1'h1);
    endtask
    task automatic t_ident();
        rd(OFS_VARIANT_ID, {16'h0, VARIANT_ID_VME});
        rd(OFS_SERIAL_REV, {16'h0, TYPE_VME, 12'h205});
        rd(OFS_CONTROL, 32'h0);
        rd(OFS_CONDITION, ST);
        rd(OFS_SCRATCH_HIGH, 32'h0);
        acc(A32, AM_A32_NP, 1'h0, 1'h1, 32'h0, {VARIANT_ID_VME, 16'h1205}, 1'h1);
        rd(19'h0000C, 32'h0);
    endtask
    task automatic t_fields();
        wr(OFS_VARIANT_ID, 32'hFFFF);
        wr(OFS_CONDITION, 32'hFFFF);
        rd(OFS_VARIANT_ID, {16'h0, VARIANT_ID_VME});
        rd(OFS_CONDITION, ST);
        wr(OFS_CONTROL, 32'hFFFF);
        rd(OFS_CONTROL, 32'h7);
        chk({30'h0, crst, cdis}, 32'h3);
        wr(OFS_CONTROL, 32'h0);
        chk({30'h0, crst, cdis}, 32'h0);
    endtask
    task automatic t_scratch();
        acc(A32 | 32'h8, AM_A32_SV, 1'h1, 1'h1, 32'hA5C3_1E96, 32'h0, 1'h1);
        rd(OFS_SCRATCH_LOW, 32'hA5C3);
        rd(OFS_SCRATCH_HIGH, 32'h1E96);
        acc(A24 | 32'h8, AM_A24_NP, 1'h0, 1'h1, 32'h0, 32'hA5C3_1E96, 1'h1);
    endtask
    task automatic t_refuse();
        acc(A24, 6'h3E, 1'h0, 1'h0, 32'h0, 32'h0, 1'h0);
        acc(A24, AM_A32_NP, 1'h0, 1'h0, 32'h0, 32'h0, 1'h0);
        acc(32'h0070_0000, AM_A24_NP, 1'h0, 1'h0, 32'h0, 32'h0, 1'h0);
    endtask
    task automatic t_loss();
        loss = 1'h1;
        tick(8);
        loss = 1'h0;
        tick(8);
        rd(OFS_CONDITION, ST | 32'h1);
        wr(OFS_CONTROL, 32'h0);
        rd(OFS_CONDITION, ST | 32'h1);
        wr(OFS_CONTROL, 32'h4);
        rd(OFS_CONDITION, ST);
        chk({31'h0, tled}, 32'h0);
        wr(OFS_CONTROL, 32'h0);
    endtask
    task automatic t_can();
        act = 1'h1;
        tick(8);
        act = 1'h0;
        rd(OFS_CONDITION, ST | 32'h2);
        tick(40);
        rd(OFS_CONDITION, ST);
        chk({31'h0, cled}, 32'h0);
    endtask
    task automatic t_mem();
        acc(A24 | 32'h10, AM_A24_NP, 1'h1, 1'h1, 32'h1234_5678, 32'h0, 1'h1);
        acc(A24 | 32'h1000, AM_A24_NP, 1'h1, 1'h1, 32'h8765_4321, 32'h0, 1'h1);
        rd(19'h00012, 32'h5678);
        acc(A24 | 32'h1000, AM_A24_SV, 1'h0, 1'h1, 32'h0, 32'h8765_4321, 1'h1);
        tick(2);
        chk(mrd, 32'h1234_5678);
        ma = 10'h001;
        mwd = 32'hCAFE_F00D;
        mwe = 1'h1;
        tick(1);
        mwe = 1'h0;
        acc(A24 | 32'h14, AM_A24_SV, 1'h0, 1'h1, 32'h0, 32'hCAFE_F00D, 1'h1);
    endtask
    task automatic t_custom();
        std_vme = 1'h0;
        geo = 9'h050;
        tick(8);
        acc(A24, 6'h00, 1'h0, 1'h0, 32'h0, {16'h0, VARIANT_ID_CUSTOM}, 1'h1);
        acc(A24 | 32'h2, 6'h3E, 1'h0, 1'h0, 32'h0, {16'h0, TYPE_CUSTOM, 12'h205}, 1'h1);
        rd(OFS_CONDITION, 32'h14);
    endtask
    initial
    begin
        tick(2);
        rst = 1'h0;
        tick(6);
        t_ident();
        t_fields();
        t_scratch();
        t_refuse();
        t_loss();
        t_can();
        t_mem();
        t_custom();
        results();
    end
endmodule
`default_nettype wire
